/* rtl/fault_resp_defs.vh */
`ifndef FAULT_RESP_DEFS_VH
`define FAULT_RESP_DEFS_VH
// Regulator count: seven buck, four linear (linear2 is index 8).
`define NUM_REG 11
`define NUM_BUCK 7
`define LIN2_IDX 8
// Clock rate in kHz for timing derivations.
`define CLK_KHZ 25000
// Times in microseconds.
`define CURRENT_LIMIT_FAULT_DB_US 16'h03e8
`define OVUV_PERSIST_US 16'h012c
`define REEN_WAIT_US 16'h01f4
`define PDD_1_US 16'h05dc
`define PDD_2_US 16'h1388
`define PDD_3_US 16'h2710
// One microsecond tick derived from the clock.
`define TICK_CYC (`CLK_KHZ / 1000)
// Debounce selector codes for OV/UV, in microseconds per code.
`define DB_SEL_0_US 16'h0000
`define DB_SEL_1_US 16'h000a
`define DB_SEL_2_US 16'h0032
`define DB_SEL_3_US 16'h0064
// Reset values.
`define PDD_SEL_RST 2'h0
`define FAULT_LIMIT_RST 4'h0
`endif

/* rtl/regulator_fault_response.v */
`timescale 1ns/1ps
`include "fault_resp_defs.vh"
// Functional notes
// - Power-on input is masked from power-down start until the delay expires.
// - Delay selector codes 00,01,10,11 give 0, 1.5, 5.0 and 10 ms.
// - Delay selector defaults to 00 when nothing is programmed.
// - Monitor current-limit, overvoltage, undervoltage per regulator in active states.
// - Unmasked fault events pull the active-low interrupt output.
// - Fault configuration returns to defaults after each power-up; host reprograms.
// - Per-fault keep-on bit: 0 disables regulator on that fault, 1 keeps on.
// - Current limit counts after 1.0 ms persistence; disable happens immediately.
// - Over/undervoltage debounced by selector; disable after 300 us further persistence.
// - Re-enable bit 0 keeps regulator off; 1 restores prior state.
// - Restore 500 us after fault clears; current limit adds 1.0 ms clear debounce.
// - Linear2 on hardware pin obeys its re-enable bit regardless of pin.
// - Writing linear2 software enable releases its latched fault disable.
// - On each fault event, increment counter unless it equals the limit; events in the same cycle add one in total.
// - A further event while the counter sits at the limit starts a power-down sequence.
// - A limit of zero disables counter-triggered power-down.
module regulator_fault_response (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire power_on_input_in,
  input wire powerdown_start_in,
  input wire powerdown_done_in,
  input wire powerup_done_in,
  input wire monitor_active_in,
  input wire [1:0] post_powerdown_delay_sel_in,
  input wire [10:0] reg_enable_req_in,
  input wire [10:0] current_limit_fault_in,
  input wire [10:0] overvoltage_in,
  input wire [10:0] undervoltage_in,
  input wire [10:0] fault_mask_in,
  input wire [6:0] buck_currentlimit_keep_on_in,
  input wire [6:0] buck_overvoltage_keep_on_in,
  input wire [6:0] buck_undervoltage_keep_on_in,
  input wire [3:0] linear_currentlimit_keep_on_in,
  input wire [3:0] linear_overvoltage_keep_on_in,
  input wire [3:0] linear_undervoltage_keep_on_in,
  input wire [6:0] buck_fault_reenable_in,
  input wire [3:0] linear_fault_reenable_in,
  input wire cfg_write_in,
  input wire [1:0] overvoltage_debounce_sel_in,
  input wire [1:0] undervoltage_debounce_sel_in,
  input wire linear2_hw_enable_pin_in,
  input wire linear2_hw_mode_in,
  input wire linear2_sw_enable_write_in,
  input wire [3:0] fault_count_limit_in,
  input wire fault_count_clear_in,
  output wire [10:0] reg_enable_out,
  output reg [10:0] fault_status_out,
  output wire interrupt_out_n,
  output reg [3:0] global_fault_count_out,
  output reg fault_powerdown_req_out,
  output wire power_on_gated_out,
  output reg power_on_masked_out
);

  localparam NR = `NUM_REG;
  localparam TICK = `TICK_CYC;
  localparam [15:0] CURRENT_LIMIT_FAULT_US = `CURRENT_LIMIT_FAULT_DB_US;
  localparam [15:0] PERS_US = `OVUV_PERSIST_US;
  localparam [15:0] REEN_US = `REEN_WAIT_US;
  localparam [1:0] PD_IDLE = 2'h0;
  localparam [1:0] PD_SEQ = 2'h1;
  localparam [1:0] PD_WAIT = 2'h2;

  // Delay selector to microseconds.
  function [15:0] pdd_us;
    input [1:0] sel;
    begin
      case (sel)
        2'h1: pdd_us = `PDD_1_US;
        2'h2: pdd_us = `PDD_2_US;
        2'h3: pdd_us = `PDD_3_US;
        default: pdd_us = 16'h0000;
      endcase
    end
  endfunction

  // Debounce selector to microseconds, shared by both voltage monitors.
  function [15:0] db_us;
    input [1:0] sel;
    begin
      case (sel)
        2'h1: db_us = `DB_SEL_1_US;
        2'h2: db_us = `DB_SEL_2_US;
        2'h3: db_us = `DB_SEL_3_US;
        default: db_us = `DB_SEL_0_US;
      endcase
    end
  endfunction

  // Pin and fault inputs come from the analog side, so synchronise them.
  reg [34:0] sync1_reg;
  reg [34:0] sync2_reg;
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_reg <= 35'h000000000;
      sync2_reg <= 35'h000000000;
    end else begin
      sync1_reg <= {linear2_hw_enable_pin_in, power_on_input_in,
                    undervoltage_in, overvoltage_in, current_limit_fault_in};
      sync2_reg <= sync1_reg;
    end
  end
  wire [10:0] current_limit_fault_s = sync2_reg[10:0];
  wire [10:0] ov_s = sync2_reg[21:11];
  wire [10:0] uv_s = sync2_reg[32:22];
  wire power_on_input_s = sync2_reg[33];
  wire l2pin_s = sync2_reg[34];

  // One microsecond timebase shared by every interval counter.
  reg [4:0] pre_reg;
  wire tick = (pre_reg == TICK - 1);
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      pre_reg <= 5'h00;
    else if (tick)
      pre_reg <= 5'h00;
    else
      pre_reg <= pre_reg + 5'h01;
  end

  wire [NR-1:0] keep_il = {linear_currentlimit_keep_on_in,
                           buck_currentlimit_keep_on_in};
  wire [NR-1:0] keep_ov = {linear_overvoltage_keep_on_in,
                           buck_overvoltage_keep_on_in};
  wire [NR-1:0] keep_uv = {linear_undervoltage_keep_on_in,
                           buck_undervoltage_keep_on_in};
  wire [NR-1:0] reen = {linear_fault_reenable_in, buck_fault_reenable_in};
  wire [15:0] overvoltage_debounce_sel = db_us(overvoltage_debounce_sel_in);
  wire [15:0] undervoltage_debounce_sel = db_us(undervoltage_debounce_sel_in);

  // Per-regulator debounce, persistence and recovery counters.
  reg [15:0] il_cnt_reg [0:NR-1];
  reg [15:0] ov_cnt_reg [0:NR-1];
  reg [15:0] uv_cnt_reg [0:NR-1];
  reg [15:0] rec_cnt_reg [0:NR-1];
  reg [NR-1:0] il_det_reg;
  reg [NR-1:0] off_reg;
  reg [NR-1:0] latched_reg;
  reg [NR-1:0] ev_pulse_reg;
  wire [NR-1:0] ov_det;
  wire [NR-1:0] uv_det;
  wire [NR-1:0] ov_trip;
  wire [NR-1:0] uv_trip;

  genvar g;
  generate
    for (g = 0; g < NR; g = g + 1) begin : chan
      // Detection means the filtered condition has held past its debounce.
      assign ov_det[g] = ov_s[g] && (ov_cnt_reg[g] >= overvoltage_debounce_sel);
      assign uv_det[g] = uv_s[g] && (uv_cnt_reg[g] >= undervoltage_debounce_sel);
      assign ov_trip[g] = ov_s[g] && (ov_cnt_reg[g] >= overvoltage_debounce_sel + PERS_US);
      assign uv_trip[g] = uv_s[g] && (uv_cnt_reg[g] >= undervoltage_debounce_sel + PERS_US);

      wire any_det = il_det_reg[g] | ov_det[g] | uv_det[g];
      wire trip = monitor_active_in & (
        (il_det_reg[g] & ~keep_il[g]) |
        (ov_trip[g] & ~keep_ov[g]) |
        (uv_trip[g] & ~keep_uv[g]));
      // Linear2 on hardware pin is released by a software enable write.
      wire l2_rel = (g == `LIN2_IDX) && linear2_sw_enable_write_in;
      // A host toggle of the enable request clears a latched disable.
      wire host_rel = !reg_enable_req_in[g];

      always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          il_cnt_reg[g] <= 16'h0000;
          ov_cnt_reg[g] <= 16'h0000;
          uv_cnt_reg[g] <= 16'h0000;
          rec_cnt_reg[g] <= 16'h0000;
          il_det_reg[g] <= 1'b0;
          off_reg[g] <= 1'b0;
          latched_reg[g] <= 1'b0;
          ev_pulse_reg[g] <= 1'b0;
        end else begin
          ev_pulse_reg[g] <= 1'b0;
          // Current limit debounce both on set and on clear.
          if (current_limit_fault_s[g] != il_det_reg[g]) begin
            if (tick)
              il_cnt_reg[g] <= il_cnt_reg[g] + 16'h0001;
            if (il_cnt_reg[g] >= CURRENT_LIMIT_FAULT_US) begin
              il_det_reg[g] <= current_limit_fault_s[g];
              il_cnt_reg[g] <= 16'h0000;
              if (current_limit_fault_s[g] && monitor_active_in)
                ev_pulse_reg[g] <= 1'b1;
            end
          end else
            il_cnt_reg[g] <= 16'h0000;
          // Voltage monitors count held time, saturating.
          if (!ov_s[g])
            ov_cnt_reg[g] <= 16'h0000;
          else if (tick && ov_cnt_reg[g] != 16'hffff)
            ov_cnt_reg[g] <= ov_cnt_reg[g] + 16'h0001;
          if (!uv_s[g])
            uv_cnt_reg[g] <= 16'h0000;
          else if (tick && uv_cnt_reg[g] != 16'hffff)
            uv_cnt_reg[g] <= uv_cnt_reg[g] + 16'h0001;
          if (monitor_active_in && tick && ((ov_s[g] &&
              ov_cnt_reg[g] == overvoltage_debounce_sel) || (uv_s[g] && uv_cnt_reg[g] == undervoltage_debounce_sel)))
            ev_pulse_reg[g] <= 1'b1;
          // Disable and recovery.
          if (trip) begin
            off_reg[g] <= 1'b1;
            latched_reg[g] <= ~reen[g];
            rec_cnt_reg[g] <= 16'h0000;
          end else if (off_reg[g] && !any_det) begin
            if (latched_reg[g]) begin
              if (host_rel || l2_rel) begin
                off_reg[g] <= 1'b0;
                latched_reg[g] <= 1'b0;
              end
            end else if (rec_cnt_reg[g] >= REEN_US) begin
              off_reg[g] <= 1'b0;
              rec_cnt_reg[g] <= 16'h0000;
            end else if (tick)
              rec_cnt_reg[g] <= rec_cnt_reg[g] + 16'h0001;
          end else
            rec_cnt_reg[g] <= 16'h0000;
        end
      end
    end
  endgenerate

  // Linear2 may follow its hardware pin; fault gating still applies.
  wire [NR-1:0] req_eff = linear2_hw_mode_in ?
    (reg_enable_req_in & ~(11'h001 << `LIN2_IDX)) |
    ({10'h000, l2pin_s} << `LIN2_IDX) : reg_enable_req_in;
  assign reg_enable_out = req_eff & ~off_reg;

  // Sticky status, events win over host clear; cleared after power-up.
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      fault_status_out <= 11'h000;
    else if (powerup_done_in)
      fault_status_out <= ev_pulse_reg;
    else if (fault_count_clear_in)
      fault_status_out <= ev_pulse_reg;
    else
      fault_status_out <= fault_status_out | ev_pulse_reg;
  end
  assign interrupt_out_n = ~|(fault_status_out & ~fault_mask_in);

  // Global fault counter and limit-triggered power-down.
  reg [3:0] limit_reg;
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      global_fault_count_out <= 4'h0;
      limit_reg <= `FAULT_LIMIT_RST;
      fault_powerdown_req_out <= 1'b0;
    end else begin
      fault_powerdown_req_out <= 1'b0;
      if (powerup_done_in)
        limit_reg <= `FAULT_LIMIT_RST;
      else if (cfg_write_in)
        limit_reg <= fault_count_limit_in;
      if (|ev_pulse_reg && global_fault_count_out != limit_reg)
        global_fault_count_out <= global_fault_count_out + 4'h1;
      else if (fault_count_clear_in)
        global_fault_count_out <= 4'h0;
      if (|ev_pulse_reg && limit_reg != 4'h0 &&
          global_fault_count_out == limit_reg)
        fault_powerdown_req_out <= 1'b1;
    end
  end

  // Power-down masking of the power-on input.
  reg [1:0] pd_state_reg;
  reg [1:0] pd_sel_reg;
  reg [15:0] pd_cnt_reg;
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      pd_sel_reg <= `PDD_SEL_RST;
    else
      pd_sel_reg <= post_powerdown_delay_sel_in;
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pd_state_reg <= PD_IDLE;
      pd_cnt_reg <= 16'h0000;
      power_on_masked_out <= 1'b0;
    end else begin
      case (pd_state_reg)
        PD_IDLE: begin
          if (powerdown_start_in || fault_powerdown_req_out) begin
            pd_state_reg <= PD_SEQ;
            power_on_masked_out <= 1'b1;
          end
        end
        PD_SEQ: begin
          pd_cnt_reg <= 16'h0000;
          if (powerdown_done_in)
            pd_state_reg <= PD_WAIT;
        end
        PD_WAIT: begin
          if (pd_cnt_reg >= pdd_us(pd_sel_reg)) begin
            pd_state_reg <= PD_IDLE;
            power_on_masked_out <= 1'b0;
          end else if (tick)
            pd_cnt_reg <= pd_cnt_reg + 16'h0001;
        end
        default: begin
          pd_state_reg <= PD_IDLE;
          power_on_masked_out <= 1'b0;
        end
      endcase
    end
  end
  assign power_on_gated_out = power_on_input_s & ~power_on_masked_out;

endmodule // regulator_fault_response

/* verif/regulator_fault_response_checker.sv */
`timescale 1ns/1ps
// Port-level checks; one clock domain, so clocking and reset are shared.
module regulator_fault_response_checker (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire power_on_input_in,
  input wire powerdown_start_in,
  input wire powerdown_done_in,
  input wire powerup_done_in,
  input wire fault_count_clear_in,
  input wire [1:0] post_powerdown_delay_sel_in,
  input wire [10:0] reg_enable_req_in,
  input wire [10:0] fault_mask_in,
  input wire [10:0] reg_enable_out,
  input wire [10:0] fault_status_out,
  input wire interrupt_out_n,
  input wire [3:0] global_fault_count_out,
  input wire fault_powerdown_req_out,
  input wire power_on_gated_out,
  input wire power_on_masked_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Mask may be registered, so only compare once it has been steady.
  property p_int;
    $stable(fault_mask_in) |->
      interrupt_out_n == ~|(fault_status_out & ~fault_mask_in);
  endproperty
  property p_step;
    global_fault_count_out != $past(global_fault_count_out) |->
      (global_fault_count_out == $past(global_fault_count_out) + 4'h1) ||
      (global_fault_count_out == 4'h0);
  endproperty
  property p_pdreq;
    fault_powerdown_req_out |-> global_fault_count_out != 4'h0;
  endproperty
  // The pin reaches the output two edges late, and only while unmasked.
  property p_gate;
    $past(rst_n_in, 2) |-> power_on_gated_out ==
      (!power_on_masked_out && $past(power_on_input_in, 2));
  endproperty
  property p_start;
    powerdown_start_in |-> ##[1:2] power_on_masked_out;
  endproperty
  // With no delay selected the mask drops within 60 cycles, about two and a half timebase ticks.
  property p_nodelay;
    powerdown_done_in && !powerdown_start_in &&
      post_powerdown_delay_sel_in == 2'h0 |-> ##[1:60] !power_on_masked_out;
  endproperty
  property p_subset;
    (reg_enable_out[6:0] & ~reg_enable_req_in[6:0]) == 7'h00;
  endproperty
  property p_sticky;
    |($past(fault_status_out) & ~fault_status_out) |->
      $past(fault_count_clear_in) || $past(powerup_done_in) ||
      $past(fault_count_clear_in, 2) || $past(powerup_done_in, 2);
  endproperty
  a_int: assert property (p_int) else $error("interrupt level wrong");
  a_step: assert property (p_step) else $error("count jump");
  a_pdreq: assert property (p_pdreq) else $error("power-down at 0");
  a_gate: assert property (p_gate) else $error("power-on leaked");
  a_start: assert property (p_start) else $error("mask not set");
  a_nodelay: assert property (p_nodelay) else $error("mask held");
  a_subset: assert property (p_subset) else $error("unrequested on");
  a_sticky: assert property (p_sticky) else $error("status lost");
  c_pd: cover property ($rose(fault_powerdown_req_out));
  c_int: cover property ($fell(interrupt_out_n));
  c_mask: cover property ($rose(power_on_masked_out));
endmodule // regulator_fault_response_checker
bind regulator_fault_response regulator_fault_response_checker i_chk (
  .core_clk_in, .rst_n_in, .power_on_input_in,
  .powerdown_start_in, .powerdown_done_in,
  .powerup_done_in, .fault_count_clear_in, .post_powerdown_delay_sel_in,
  .reg_enable_req_in, .fault_mask_in, .reg_enable_out, .fault_status_out,
  .interrupt_out_n, .global_fault_count_out, .fault_powerdown_req_out,
  .power_on_gated_out, .power_on_masked_out);

/* verif/fault_host_model.sv */
`timescale 1ns/1ps
// Host side: boots the fault config and restarts latched-off regulators.
module fault_host_model (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire powerup_done_in,
  input wire [3:0] limit_in,
  input wire [10:0] restart_in,
  output reg cfg_write_out,
  output reg [3:0] fault_count_limit_out,
  output reg [10:0] reg_enable_req_out,
  output reg linear2_sw_enable_write_out
);
  reg boot_reg;
  // Config is rewritten after every power-up since the device forgets it.
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boot_reg <= 1'b1;
      cfg_write_out <= 1'b0;
      fault_count_limit_out <= 4'h0;
      reg_enable_req_out <= 11'h7ff;
      linear2_sw_enable_write_out <= 1'b0;
    end else begin
      boot_reg <= 1'b0;
      cfg_write_out <= boot_reg | powerup_done_in;
      fault_count_limit_out <= limit_in;
      reg_enable_req_out <= ~restart_in;
      linear2_sw_enable_write_out <= restart_in[8];
    end
  end
endmodule // fault_host_model

/* verif/regulator_fault_response_tb.sv */
`timescale 1ns/1ps
`include "fault_resp_defs.vh"
module regulator_fault_response_tb;
  reg core_clk_in, rst_n_in, power_on_input_in, powerdown_start_in;
  reg powerdown_done_in, powerup_done_in, monitor_active_in;
  reg [1:0] post_powerdown_delay_sel_in, overvoltage_debounce_sel_in;
  reg [1:0] undervoltage_debounce_sel_in;
  reg [10:0] current_limit_fault_in, overvoltage_in, undervoltage_in;
  reg [10:0] fault_mask_in, restart;
  reg [6:0] buck_currentlimit_keep_on_in, buck_overvoltage_keep_on_in;
  reg [6:0] buck_undervoltage_keep_on_in, buck_fault_reenable_in;
  reg [3:0] linear_currentlimit_keep_on_in, linear_overvoltage_keep_on_in;
  reg [3:0] linear_undervoltage_keep_on_in, linear_fault_reenable_in;
  reg linear2_hw_enable_pin_in, linear2_hw_mode_in, fault_count_clear_in;
  reg pd_seen;
  reg [31:0] rnd;
  wire cfg_write_in, linear2_sw_enable_write_in, interrupt_out_n;
  wire fault_powerdown_req_out, power_on_gated_out, power_on_masked_out;
  wire [3:0] fault_count_limit_in, global_fault_count_out;
  wire [10:0] reg_enable_req_in, reg_enable_out, fault_status_out;
  integer n_errors, num_checks, k;
  regulator_fault_response i_regulator_fault_response (.core_clk_in,
    .rst_n_in, .power_on_input_in, .powerdown_start_in, .powerdown_done_in,
    .powerup_done_in, .monitor_active_in, .post_powerdown_delay_sel_in,
    .reg_enable_req_in, .current_limit_fault_in, .overvoltage_in,
    .undervoltage_in, .fault_mask_in, .buck_currentlimit_keep_on_in,
    .buck_overvoltage_keep_on_in, .buck_undervoltage_keep_on_in,
    .linear_currentlimit_keep_on_in, .linear_overvoltage_keep_on_in,
    .linear_undervoltage_keep_on_in, .buck_fault_reenable_in,
    .linear_fault_reenable_in, .cfg_write_in, .overvoltage_debounce_sel_in,
    .undervoltage_debounce_sel_in, .linear2_hw_enable_pin_in,
    .linear2_hw_mode_in, .linear2_sw_enable_write_in, .fault_count_limit_in,
    .fault_count_clear_in, .reg_enable_out, .fault_status_out,
    .interrupt_out_n, .global_fault_count_out, .fault_powerdown_req_out,
    .power_on_gated_out, .power_on_masked_out);
  fault_host_model i_fault_host_model (.core_clk_in, .rst_n_in,
    .powerup_done_in, .limit_in(4'h2), .restart_in(restart),
    .cfg_write_out(cfg_write_in), .fault_count_limit_out(fault_count_limit_in),
    .reg_enable_req_out(reg_enable_req_in),
    .linear2_sw_enable_write_out(linear2_sw_enable_write_in));
  function [31:0] xs(input [31:0] v);
    begin
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      xs = v ^ (v << 5);
    end
  endfunction
  function exp_int(input [10:0] st, input [10:0] m);
    exp_int = ~|(st & ~m);
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wait_us(input integer n);
    begin
      repeat (n * `TICK_CYC) @(posedge core_clk_in);
      #1;
    end
  endtask
  // A start pulse followed at once by the sequencer's done pulse.
  task power_down(input [1:0] sel);
    begin
      post_powerdown_delay_sel_in = sel;
      powerdown_start_in = 1'b1;
      @(posedge core_clk_in);
      #1 powerdown_start_in = 1'b0;
      powerdown_done_in = 1'b1;
      @(posedge core_clk_in);
      #1 powerdown_done_in = 1'b0;
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  // Catches a power-down request pulse that lasts only one cycle.
  always @(posedge core_clk_in)
    if (fault_powerdown_req_out === 1'b1) pd_seen <= 1'b1;
  // Cuts a hang short; the sequence needs roughly 65700 cycles.
  initial begin
    repeat (90000) @(posedge core_clk_in);
    n_errors = n_errors + 1;
    final_report;
  end
  initial begin
    {rst_n_in, power_on_input_in, powerdown_start_in, pd_seen} = 4'h0;
    {powerdown_done_in, powerup_done_in, fault_count_clear_in} = 3'h0;
    {post_powerdown_delay_sel_in, overvoltage_debounce_sel_in} = 4'h0;
    {current_limit_fault_in, overvoltage_in, undervoltage_in} = 33'h0;
    {fault_mask_in, restart, linear2_hw_mode_in} = 23'h0;
    {buck_currentlimit_keep_on_in, buck_overvoltage_keep_on_in} = 14'h3fff;
    buck_undervoltage_keep_on_in = 7'h7f;
    buck_fault_reenable_in = 7'h00;
    monitor_active_in = 1'b1;
    n_errors = 0;
    num_checks = 0;
    rnd = xs(32'h47b2);
    {linear_currentlimit_keep_on_in, linear_overvoltage_keep_on_in} = rnd[7:0];
    {linear_undervoltage_keep_on_in, linear_fault_reenable_in} = rnd[15:8];
    {undervoltage_debounce_sel_in, linear2_hw_enable_pin_in} = rnd[18:16];
    repeat (10) @(posedge core_clk_in);
    #1 rst_n_in = 1'b1;
    repeat (3) @(posedge core_clk_in);
    #1 check({interrupt_out_n, global_fault_count_out}, 5'h10);
    check(reg_enable_out, 11'h7ff);
    power_on_input_in = 1'b1;
    power_down(2'h0);
    repeat (60) @(posedge core_clk_in);
    #1 check({power_on_masked_out, power_on_gated_out}, 2'h1);
    // Random overvoltage victim and interrupt mask; bit 0 stays unmasked.
    rnd = xs(rnd);
    k = 1 + rnd[7:0] % 6;
    fault_mask_in = rnd[18:8] & 11'h7fe;
    buck_currentlimit_keep_on_in = 7'h7e;
    buck_overvoltage_keep_on_in = ~(7'h01 << k);
    buck_fault_reenable_in = 7'h01 << k;
    current_limit_fault_in = 11'h001;
    overvoltage_in = 11'h001 << k;
    wait_us(100);
    check(fault_status_out, 11'h001 << k);
    check(reg_enable_out[k], 1'b1);
    check({pd_seen, global_fault_count_out}, 5'h01);
    check(interrupt_out_n, exp_int(11'h001 << k, fault_mask_in));
    wait_us(250);
    check(reg_enable_out[k], 1'b0);
    overvoltage_in = 11'h000;
    wait_us(450);
    check(reg_enable_out[k], 1'b0);
    wait_us(100);
    check(reg_enable_out[k], 1'b1);
    wait_us(50);
    check(fault_status_out[0], 1'b0);
    wait_us(100);
    check({fault_status_out[0], reg_enable_out[0]}, 2'h2);
    check({pd_seen, global_fault_count_out}, 5'h02);
    // A further event with the count at its limit asks for power-down.
    overvoltage_in = 11'h001 << k;
    wait_us(2);
    overvoltage_in = 11'h000;
    check({pd_seen, global_fault_count_out}, 5'h12);
    check(interrupt_out_n, 1'b0);
    current_limit_fault_in = 11'h000;
    power_down(2'h1);
    wait_us(1400);
    check({power_on_masked_out, power_on_gated_out}, 2'h2);
    wait_us(150);
    check({power_on_masked_out, power_on_gated_out}, 2'h1);
    check(reg_enable_out[0], 1'b0);
    restart = 11'h101;
    @(posedge core_clk_in);
    #1 restart = 11'h000;
    repeat (5) @(posedge core_clk_in);
    #1 check(reg_enable_out[0], 1'b1);
    {powerup_done_in, fault_count_clear_in} = 2'h3;
    @(posedge core_clk_in);
    #1 {powerup_done_in, fault_count_clear_in} = 2'h0;
    repeat (5) @(posedge core_clk_in);
    #1 check({fault_status_out, global_fault_count_out}, 15'h0);
    check(interrupt_out_n, 1'b1);
    // Outside the monitored states a fault must leave no event behind.
    monitor_active_in = 1'b0;
    overvoltage_in = 11'h001 << k;
    wait_us(20);
    check(fault_status_out, 11'h000);
    overvoltage_in = 11'h000;
    wait_us(1);
    monitor_active_in = 1'b1;
    // Linear2 under pin control follows the synchronised pin level.
    linear2_hw_mode_in = 1'b1;
    repeat (3) @(posedge core_clk_in);
    #1 check(reg_enable_out[8], linear2_hw_enable_pin_in);
    linear2_hw_enable_pin_in = ~linear2_hw_enable_pin_in;
    repeat (3) @(posedge core_clk_in);
    #1 check(reg_enable_out[8], linear2_hw_enable_pin_in);
    final_report;
  end
endmodule // regulator_fault_response_tb
